//--- rtl/ext_bus_cfg.svh
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_ADDRESS_UPDATE_SELECT 20'hE_E01E
`define ADDR_AREA_BUS_WIDTH 20'hE_E020
`define ADDR_AREA_ACCESS_STATES 20'hE_E021
`define ADDR_WAIT_CONTROL_HIGH 20'hE_E022
`define ADDR_WAIT_CONTROL_LOW 20'hE_E023
`define ADDR_BUS_CYCLE_CONTROL 20'hE_E024
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADDRESS_UPDATE_SCHEME_POS 0
`define IDLE_INSERT_POS 7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ADDRESS_UPDATE_SELECT 8'hFF
`define RST_AREA_BUS_WIDTH 8'hFF
`define RST_AREA_ACCESS_STATES 8'hFF
`define RST_WAIT_CONTROL 8'hFF
`define RST_BUS_CYCLE_CONTROL 8'h04
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define TWO_STATE_COUNT 3'h2
`define THREE_STATE_COUNT 3'h3
`endif

//--- rtl/ext_bus_pkg.sv
package ext_bus_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GAP,
    ST_ACCESS
  } access_state_t;
endpackage

//--- rtl/external_bus_area_control.sv
`include "ext_bus_cfg.svh"
// Functional notes
// [R1] Per-area width bit: 0 gives 16-bit bus, 1 gives 8-bit bus.
// [R2] Per-area state bit: 0 gives two-state access, 1 gives three-state.
// [R3] Two-bit wait field per area inserts zero to three program wait states.
// [R4] High wait register holds areas 7-4, low holds 3-0, two bits each, descending.
// [R5] Idle bit set: one idle cycle between reads to different areas.
// [R6] Software never sets the designated bus control bits to one.
// [R7] Software always writes one into bus control bit 2.
// [R8] Address control bit: 0 selects update mode 2, 1 selects mode 1 (reset).
module external_bus_area_control
  import ext_bus_pkg::*;
#(
  parameter logic [7:0] ABW_RESET = `RST_AREA_BUS_WIDTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [19:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External access request
  input wire logic acc_req,
  input wire logic [2:0] acc_area,
  input wire logic acc_read,
  // Access timing
  output logic acc_busy,
  output logic acc_done,
  output logic bus_width8,
  output logic idle_cycle,
  output logic addr_mode1
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] adr_sel_ff;
  logic [7:0] width_ff;
  logic [7:0] states_ff;
  logic [7:0] wait_hi_ff;
  logic [7:0] wait_lo_ff;
  logic [7:0] bcr_ff;
  logic [7:0] rdata_ff;
  access_state_t state_ff;
  logic [2:0] cnt_ff;
  logic [2:0] last_area_ff;
  logic last_read_ff;
  logic [2:0] pend_area_ff;
  logic busy_ff;
  logic done_ff;
  logic width8_ff;
  logic idle_ff;

  // Wait states of an area
  function automatic logic [1:0] wait_of(input logic [2:0] area, input logic [7:0] hi,
                                         input logic [7:0] lo);
    logic [7:0] sel;
    sel = area[2] ? hi : lo; // [R4]
    wait_of = 2'((sel >> {area[1:0], 1'b0}) & 8'h03); // [R3]
  endfunction

  // Total access states of an area, minus one
  function automatic logic [2:0] last_state(input logic [2:0] area, input logic [7:0] ast,
                                            input logic [7:0] hi, input logic [7:0] lo);
    logic [2:0] base;
    base = ast[area] ? `THREE_STATE_COUNT : `TWO_STATE_COUNT; // [R2]
    last_state = 3'(base + {1'b0, wait_of(area, hi, lo)} - 3'h1); // [R3]
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adr_sel_ff <= `RST_ADDRESS_UPDATE_SELECT;
      width_ff <= ABW_RESET;
      states_ff <= `RST_AREA_ACCESS_STATES;
      wait_hi_ff <= `RST_WAIT_CONTROL;
      wait_lo_ff <= `RST_WAIT_CONTROL;
      bcr_ff <= `RST_BUS_CYCLE_CONTROL;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_ADDRESS_UPDATE_SELECT) begin
        // Reserved bits stay at one
        adr_sel_ff[`ADDRESS_UPDATE_SCHEME_POS] <= reg_wdata[`ADDRESS_UPDATE_SCHEME_POS]; // [R8]
      end else if (reg_addr == `ADDR_AREA_BUS_WIDTH) begin
        width_ff <= reg_wdata; // [R1]
      end else if (reg_addr == `ADDR_AREA_ACCESS_STATES) begin
        states_ff <= reg_wdata; // [R2]
      end else if (reg_addr == `ADDR_WAIT_CONTROL_HIGH) begin
        wait_hi_ff <= reg_wdata; // [R4]
      end else if (reg_addr == `ADDR_WAIT_CONTROL_LOW) begin
        wait_lo_ff <= reg_wdata; // [R4]
      end else if (reg_addr == `ADDR_BUS_CYCLE_CONTROL) begin
        // Stored as written; a bad value is the caller's problem
        bcr_ff <= reg_wdata; // [R6] [R7]
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_ADDRESS_UPDATE_SELECT) begin
        rdata_ff <= adr_sel_ff;
      end else if (reg_addr == `ADDR_AREA_BUS_WIDTH) begin
        rdata_ff <= width_ff;
      end else if (reg_addr == `ADDR_AREA_ACCESS_STATES) begin
        rdata_ff <= states_ff;
      end else if (reg_addr == `ADDR_WAIT_CONTROL_HIGH) begin
        rdata_ff <= wait_hi_ff;
      end else if (reg_addr == `ADDR_WAIT_CONTROL_LOW) begin
        rdata_ff <= wait_lo_ff;
      end else if (reg_addr == `ADDR_BUS_CYCLE_CONTROL) begin
        rdata_ff <= bcr_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  logic take_req;
  logic need_gap;
  assign take_req = acc_req && (state_ff == ST_IDLE);
  // Only reads following reads across areas pay the gap
  assign need_gap = bcr_ff[`IDLE_INSERT_POS] && acc_read && last_read_ff &&
                    (acc_area != last_area_ff); // [R5]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      pend_area_ff <= 3'h0;
      last_area_ff <= 3'h0;
      last_read_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      width8_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      idle_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (take_req) begin
            busy_ff <= 1'b1;
            pend_area_ff <= acc_area;
            last_area_ff <= acc_area;
            last_read_ff <= acc_read;
            width8_ff <= width_ff[acc_area]; // [R1]
            cnt_ff <= last_state(acc_area, states_ff, wait_hi_ff, wait_lo_ff);
            if (need_gap) begin
              state_ff <= ST_GAP; // [R5]
              idle_ff <= 1'b1;
            end else begin
              state_ff <= ST_ACCESS;
            end
          end
        end
        ST_GAP: begin
          state_ff <= ST_ACCESS;
        end
        ST_ACCESS: begin
          if (cnt_ff == 3'h0) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end else begin
            cnt_ff <= 3'(cnt_ff - 3'h1); // [R2] [R3]
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign reg_rdata = rdata_ff;
  assign acc_busy = busy_ff;
  assign acc_done = done_ff;
  assign bus_width8 = width8_ff;
  assign idle_cycle = idle_ff;
  assign addr_mode1 = adr_sel_ff[`ADDRESS_UPDATE_SCHEME_POS]; // [R8]

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_width_select: assert property (take_req |=> bus_width8 == $past(width_ff[acc_area])) // [R1]
    else $error("bus width does not follow area width bit");
  // Done is launched on the edge that ends the last state, so it is seen one edge later
  a_two_state: assert property (take_req && !need_gap && !states_ff[acc_area] && // [R2]
      wait_of(acc_area, wait_hi_ff, wait_lo_ff) == 2'h0 |=>
      !acc_done ##1 !acc_done ##1 acc_done)
    else $error("two-state access not done in two states");
  a_three_state: assert property (take_req && !need_gap && states_ff[acc_area] && // [R2]
      wait_of(acc_area, wait_hi_ff, wait_lo_ff) == 2'h0 |=>
      !acc_done ##1 !acc_done ##1 !acc_done ##1 acc_done)
    else $error("three-state access length wrong");
  a_wait_count: assert property (take_req |=> cnt_ff == 3'($past(states_ff[acc_area]) + // [R3]
      3'h1 + {1'b0, $past(wait_of(acc_area, wait_hi_ff, wait_lo_ff))}))
    else $error("wait states loaded wrongly");
  a_wait_field: assert property (take_req && acc_area == 3'h7 |-> // [R4]
      wait_of(acc_area, wait_hi_ff, wait_lo_ff) == wait_hi_ff[7:6])
    else $error("area seven wait field misplaced");
  a_idle_gap: assert property (take_req && need_gap |=> // [R5]
      idle_cycle && state_ff == ST_GAP ##1 state_ff == ST_ACCESS)
    else $error("idle cycle missing between reads");
  a_no_gap: assert property (take_req && !need_gap |=> // [R5]
      state_ff == ST_ACCESS && !idle_cycle)
    else $error("idle cycle inserted without cause");
  a_addr_mode: assert property (reg_wr && reg_addr == `ADDR_ADDRESS_UPDATE_SELECT |=> // [R8]
      addr_mode1 == $past(reg_wdata[`ADDRESS_UPDATE_SCHEME_POS]) &&
      adr_sel_ff[7:1] == 7'h7F)
    else $error("address update scheme not taken");
  // A new request may be taken while done is high, so busy may rise right after it
  a_done_single: assert property (acc_done |-> !acc_busy ##1 !acc_done)
    else $error("done pulse longer than one cycle");

  c_gap_access: cover property (take_req && need_gap ##2 state_ff == ST_ACCESS);
  c_long_access: cover property (take_req && cnt_ff == 3'h0 ##1 cnt_ff == 3'h5);
  c_read_back: cover property (reg_rd && reg_addr == `ADDR_WAIT_CONTROL_HIGH);
endmodule // external_bus_area_control

//--- bench/ext_dev_model.sv
module ext_dev_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Cycle timing seen on the bus
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic idle_cycle,
  // Measured length and gap of the last cycle
  output logic [7:0] len_ff,
  output logic gap_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_ff;
  logic seen_ff;
  // Length is the count of busy cycles: states, waits and any idle gap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      len_ff <= 8'h00;
      seen_ff <= 1'b0;
      gap_ff <= 1'b0;
    end else if (acc_done) begin
      len_ff <= cnt_ff;
      cnt_ff <= 8'h00;
      gap_ff <= seen_ff;
      seen_ff <= 1'b0;
    end else begin
      if (acc_busy) cnt_ff <= cnt_ff + 8'h01;
      if (idle_cycle) seen_ff <= 1'b1;
    end
  end
endmodule // ext_dev_model

//--- bench/test_external_bus_area_control.sv
`include "ext_bus_cfg.svh"
module test_external_bus_area_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, reg_wr, reg_rd, acc_req, acc_read;
  logic [19:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, len, w_reg, s_reg, wl, wh;
  logic [2:0] acc_area;
  logic acc_busy, acc_done, bus_width8, idle_cycle, addr_mode1, gap;
  int n_fail = 0;
  int checked = 0;
  external_bus_area_control u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_req(acc_req), .acc_area(acc_area), .acc_read(acc_read), .acc_busy(acc_busy),
    .acc_done(acc_done), .bus_width8(bus_width8), .idle_cycle(idle_cycle),
    .addr_mode1(addr_mode1));
  ext_dev_model u_dev (.core_clk(core_clk), .rst_n(rst_n), .acc_busy(acc_busy),
    .acc_done(acc_done), .idle_cycle(idle_cycle), .len_ff(len), .gap_ff(gap));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check("rdata", reg_rdata, exp);
  endtask
  // Expected cycle count: two or three states plus the area's wait field
  function automatic logic [7:0] cyc(input logic [2:0] a);
    logic [7:0] f;
    f = (a[2] ? wh : wl) >> {a[1:0], 1'b0};
    return {6'h00, f[1:0]} + (s_reg[a] ? 8'h03 : 8'h02);
  endfunction
  task automatic acc(input logic [2:0] a, input logic r, input logic g);
    @(posedge core_clk);
    acc_req <= 1'b1;
    acc_area <= a;
    acc_read <= r;
    @(posedge core_clk);
    acc_req <= 1'b0;
    #1;
    for (int i = 0; i < 20 && acc_done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    check("done", {7'h00, acc_done}, 8'h01);
    check("width8", {7'h00, bus_width8}, {7'h00, w_reg[a]});
    @(posedge core_clk);
    #1 check("len", len, cyc(a) + {7'h00, g});
    check("gap", {7'h00, gap}, {7'h00, g});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("mode1", {7'h00, addr_mode1}, 8'h01);
    rd(`ADDR_ADDRESS_UPDATE_SELECT, 8'hFF);
    rd(`ADDR_AREA_BUS_WIDTH, 8'hFF);
    rd(`ADDR_AREA_ACCESS_STATES, 8'hFF);
    rd(`ADDR_WAIT_CONTROL_HIGH, 8'hFF);
    rd(`ADDR_WAIT_CONTROL_LOW, 8'hFF);
    rd(`ADDR_BUS_CYCLE_CONTROL, 8'h04);
    wr(20'hE_E01F, 8'h00);
    rd(20'hE_E01F, 8'h00);
  endtask
  task automatic t_mode();
    wr(`ADDR_ADDRESS_UPDATE_SELECT, 8'h00);
    rd(`ADDR_ADDRESS_UPDATE_SELECT, 8'hFE);
    check("mode1", {7'h00, addr_mode1}, 8'h00);
    wr(`ADDR_ADDRESS_UPDATE_SELECT, 8'h01);
    #1 check("mode1", {7'h00, addr_mode1}, 8'h01);
  endtask
  task automatic t_areas();
    w_reg = 8'h55;
    s_reg = 8'h33;
    wl = 8'hE4;
    wh = 8'h1B;
    wr(`ADDR_AREA_BUS_WIDTH, w_reg);
    wr(`ADDR_AREA_ACCESS_STATES, s_reg);
    wr(`ADDR_WAIT_CONTROL_LOW, wl);
    wr(`ADDR_WAIT_CONTROL_HIGH, wh);
    rd(`ADDR_WAIT_CONTROL_HIGH, wh);
    for (int a = 0; a < 8; a++) acc(a[2:0], 1'b0, 1'b0);
  endtask
  task automatic t_gap();
    // Idle insertion set, bit 2 kept at one, other designated bits left zero
    wr(`ADDR_BUS_CYCLE_CONTROL, 8'h84);
    acc(3'h1, 1'b1, 1'b0);
    acc(3'h2, 1'b1, 1'b1);
    acc(3'h2, 1'b1, 1'b0);
    acc(3'h6, 1'b0, 1'b0);
    wr(`ADDR_BUS_CYCLE_CONTROL, 8'h04);
    acc(3'h5, 1'b1, 1'b0);
    acc(3'h4, 1'b1, 1'b0);
  endtask
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #200us;
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, acc_req, acc_read, acc_area} = 8'h00;
    reg_addr = 20'h0_0000;
    reg_wdata = 8'h00;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_mode();
    t_areas();
    t_gap();
    end_of_test();
  end
endmodule // test_external_bus_area_control
